// *** rtl/mcr_regs.sv ***
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "mcr_consts.svh"
module mcr_regs (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [19:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [19:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [3:0] FIFO_UNDERRUN_EVENT,
  input wire logic [3:0] FIFO_OVERRUN_EVENT,
  input wire logic COHERENCE_EVENT,
  output logic BURST_LENGTH_SELECT,
  output logic [2:0] BURST_WORDS,
  output logic [1:0] INPUT_CLOCK_SELECT,
  output logic OUTPUT_CLOCK_SELECT,
  output logic [2:0] PLL_NUMERATOR,
  output logic [2:0] PLL_DENOMINATOR,
  output logic MEMCTL_FIFO_IRQ,
  output logic MEMCTL_MISC_IRQ,
  output logic IRQ
);
  import mcr_pkg::*;

  typedef struct packed {
    logic [8:0] sync1;
    logic [8:0] sync2;
    mcr_byte_t fifo_en;
    mcr_byte_t err_en;
    mcr_byte_t burst_clk;
    mcr_byte_t pll;
    mcr_byte_t fifo_flags;
    mcr_byte_t coh_flags;
    logic [1:0] irq_mask;
    logic [2:0] burst_words;
    logic irq;
  } mcr_regs_st_s;

  mcr_regs_st_s s_q;
  mcr_regs_st_s s_d;
  mcr_req_s req;
  mcr_rsp_s rsp;
  logic fifo_sum;
  logic misc_sum;
  logic fifo_cond;
  logic misc_cond;
  logic sum_clr_rd;
  logic fifo_clr;
  logic misc_clr;

  // Bus front end
  mcr_axil u_axil (
    .clk(MCLK),
    .rst(SYS_RST),
    .awaddr(AWADDR),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .wvalid(WVALID),
    .wready(WREADY),
    .bresp(BRESP),
    .bvalid(BVALID),
    .bready(BREADY),
    .araddr(ARADDR),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .rvalid(RVALID),
    .rready(RREADY),
    .req(req),
    .rsp(rsp)
  );

  // Index map shared by read and write decode
  function automatic logic idx_mapped(input mcr_idx_t idx);
    case (idx)
      `MCR_IDX_FIFO_EN, `MCR_IDX_ERR_EN, `MCR_IDX_BURST_CLK, `MCR_IDX_PLL,
      `MCR_IDX_RSV_A, `MCR_IDX_RSV_B, `MCR_IDX_FIFO_FLAGS,
      `MCR_IDX_COH_FLAGS, `MCR_IDX_RSV_C, `MCR_IDX_IRQ_STAT,
      `MCR_IDX_IRQ_MASK: idx_mapped = 1'b1;
      default: idx_mapped = 1'b0;
    endcase
  endfunction

  // Read data mux; reserved indexes answer zero
  always_comb begin
    rsp.rd_ok = idx_mapped(req.ridx);
    rsp.wr_ok = idx_mapped(req.widx);
    case (req.ridx)
      `MCR_IDX_FIFO_EN: rsp.rdata = s_q.fifo_en;
      `MCR_IDX_ERR_EN: rsp.rdata = s_q.err_en;
      `MCR_IDX_BURST_CLK: rsp.rdata = s_q.burst_clk;
      `MCR_IDX_PLL: rsp.rdata = s_q.pll;
      `MCR_IDX_FIFO_FLAGS: rsp.rdata = s_q.fifo_flags;
      `MCR_IDX_COH_FLAGS: rsp.rdata = s_q.coh_flags;
      `MCR_IDX_IRQ_STAT: rsp.rdata = {6'h00, misc_sum, fifo_sum};
      `MCR_IDX_IRQ_MASK: rsp.rdata = {6'h00, s_q.irq_mask};
      default: rsp.rdata = `MCR_RST_BYTE;
    endcase
  end

  // Summary causes and their clears: read clears both, a one clears one
  always_comb begin
    fifo_cond = |s_q.fifo_flags;
    misc_cond = s_q.coh_flags[`MCR_COH_BIT];
    sum_clr_rd = req.rd && (req.ridx == `MCR_IDX_IRQ_STAT);
    fifo_clr = sum_clr_rd;
    misc_clr = sum_clr_rd;
    if (req.wr && (req.widx == `MCR_IDX_IRQ_STAT)) begin
      fifo_clr = sum_clr_rd | req.wdata[0];
      misc_clr = sum_clr_rd | req.wdata[1];
    end
  end

  // FIFO fault summary bit
  mcr_sum_bit u_fifo_sum (
    .clk(MCLK),
    .rst(SYS_RST),
    .cond(fifo_cond),
    .clr(fifo_clr),
    .flag(fifo_sum)
  );

  // Coherence summary bit
  mcr_sum_bit u_misc_sum (
    .clk(MCLK),
    .rst(SYS_RST),
    .cond(misc_cond),
    .clr(misc_clr),
    .flag(misc_sum)
  );

  // Event sync, gated flags, software writes and derived outputs
  always_comb begin
    s_d = s_q;
    s_d.sync1 = {COHERENCE_EVENT, FIFO_OVERRUN_EVENT, FIFO_UNDERRUN_EVENT};
    s_d.sync2 = s_q.sync1;
    // Bits 3:0 underrun, 7:4 overrun, each behind its own enable
    s_d.fifo_flags = s_q.sync2[7:0] & s_q.fifo_en;
    s_d.coh_flags = `MCR_RST_BYTE;
    s_d.coh_flags[`MCR_COH_BIT] =
      s_q.sync2[8] & s_q.err_en[`MCR_COH_BIT];
    if (req.wr) begin
      case (req.widx)
        `MCR_IDX_FIFO_EN: s_d.fifo_en = req.wdata;
        `MCR_IDX_ERR_EN: s_d.err_en = req.wdata & `MCR_ERR_EN_WMASK;
        `MCR_IDX_BURST_CLK: begin
          s_d.burst_clk = req.wdata & `MCR_BURST_CLK_WMASK;
        end
        `MCR_IDX_PLL: s_d.pll = req.wdata & `MCR_PLL_WMASK;
        `MCR_IDX_IRQ_MASK: s_d.irq_mask = req.wdata[1:0];
        default: begin
          // Flag and reserved indexes keep their contents; ones written to the IRQ status clear summary bits
          s_d.irq = s_q.irq;
        end
      endcase
    end
    // Words per burst follow the select bit
    s_d.burst_words = s_d.burst_clk[`MCR_BURST_BIT] ?
      `MCR_BURST_LONG : `MCR_BURST_SHORT;
    s_d.irq = |({misc_sum, fifo_sum} & s_q.irq_mask);
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_q <= '{burst_words: `MCR_BURST_SHORT, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Clocking and burst controls to the controller datapath, then the interrupt outputs
  assign BURST_LENGTH_SELECT = s_q.burst_clk[`MCR_BURST_BIT];
  assign BURST_WORDS = s_q.burst_words;
  assign INPUT_CLOCK_SELECT =
    s_q.burst_clk[`MCR_ICK_HI:`MCR_ICK_LO];
  assign OUTPUT_CLOCK_SELECT = s_q.burst_clk[`MCR_OCK_BIT];
  assign PLL_NUMERATOR = s_q.pll[`MCR_NUM_HI:`MCR_NUM_LO];
  assign PLL_DENOMINATOR = s_q.pll[`MCR_DEN_HI:`MCR_DEN_LO];
  assign MEMCTL_FIFO_IRQ = fifo_sum;
  assign MEMCTL_MISC_IRQ = misc_sum;
  assign IRQ = s_q.irq;
endmodule

// *** rtl/mcr_consts.svh ***
// Notes on behaviour
// - Bit 7 of the error enable gates the coherence flag and misc irq.
// - Burst select bit 0 gives two-word bursts at 0, four-word at 1.
// - Bits 3:2 select 00 HSTL, 01 serial A, 10 serial B, 11 fabric.
// - Bit 7 picks the output clock: input clock over 2 at 0, PLL at 1.
// - PLL clock is input times numerator bits 3:1 over denominator 7:5.
// - Fault flag bits 0 to 3 report the four underruns, each enabled.
// - Fault flag bits 4 to 7 report the four overruns, each enabled.
// - Coherence register bit 7 flags incoherent words when enabled.
// - Enabled fault flags drive the FIFO irq; enables sit seven indexes below.
// - Summary bits clear on read and set again only on a fresh cause.
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH

// Register indexes; the byte address is four times the index
`define MCR_IDX_FIFO_EN 18'h30b01
`define MCR_IDX_ERR_EN 18'h30b02
`define MCR_IDX_BURST_CLK 18'h30b03
`define MCR_IDX_PLL 18'h30b04
`define MCR_IDX_RSV_A 18'h30b05
`define MCR_IDX_RSV_B 18'h30b06
`define MCR_IDX_FIFO_FLAGS 18'h30b08
`define MCR_IDX_COH_FLAGS 18'h30b09
`define MCR_IDX_RSV_C 18'h30b0a
`define MCR_IDX_IRQ_STAT 18'h30b0c
`define MCR_IDX_IRQ_MASK 18'h30b0d

// Writable bits of each control register
`define MCR_ERR_EN_WMASK 8'h80
`define MCR_BURST_CLK_WMASK 8'h8d
`define MCR_PLL_WMASK 8'hee

// Field positions
`define MCR_COH_BIT 7
`define MCR_BURST_BIT 0
`define MCR_ICK_LO 2
`define MCR_ICK_HI 3
`define MCR_OCK_BIT 7
`define MCR_NUM_LO 1
`define MCR_NUM_HI 3
`define MCR_DEN_LO 5
`define MCR_DEN_HI 7

// Reset values and encodings
`define MCR_RST_BYTE 8'h00
`define MCR_BURST_SHORT 3'h2
`define MCR_BURST_LONG 3'h4
`define MCR_RESP_OKAY 2'h0
`define MCR_RESP_SLVERR 2'h2

`endif

// *** rtl/mcr_pkg.sv ***
package mcr_pkg;

  typedef logic [7:0] mcr_byte_t;
  typedef logic [17:0] mcr_idx_t;

  // Request from the bus front end to the register file
  typedef struct packed {
    logic wr;
    mcr_idx_t widx;
    mcr_byte_t wdata;
    logic rd;
    mcr_idx_t ridx;
  } mcr_req_s;

  // Decode answer from the register file
  typedef struct packed {
    mcr_byte_t rdata;
    logic rd_ok;
    logic wr_ok;
  } mcr_rsp_s;

endpackage

// *** rtl/mcr_sum_bit.sv ***
`timescale 1ns/10ps
module mcr_sum_bit (
  input wire logic clk,
  input wire logic rst,
  input wire logic cond,
  input wire logic clr,
  output logic flag
);
  typedef struct packed {
    logic prev;
    logic flag;
  } mcr_sum_st_s;

  mcr_sum_st_s s_q;
  mcr_sum_st_s s_d;

  // Sets on a fresh rise of the cause; a set beats a clear
  always_comb begin
    s_d = s_q;
    s_d.prev = cond;
    s_d.flag = (cond & ~s_q.prev) | (s_q.flag & ~clr);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= 2'b00;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;
endmodule

// *** rtl/mcr_axil.sv ***
`timescale 1ns/10ps
`include "mcr_consts.svh"
module mcr_axil (
  input wire logic clk,
  input wire logic rst,
  input wire logic [19:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [19:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output mcr_pkg::mcr_req_s req,
  input mcr_pkg::mcr_rsp_s rsp
);
  import mcr_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    mcr_byte_t rdata;
    mcr_idx_t widx;
    mcr_byte_t wdata;
    logic wlane0;
  } mcr_axil_st_s;

  mcr_axil_st_s s_q;
  mcr_axil_st_s s_d;

  // Channel handshakes; write fires once address and data are both held
  always_comb begin
    s_d = s_q;
    req = '0;
    req.widx = s_q.widx;
    req.wdata = s_q.wdata;
    req.ridx = araddr[19:2];
    if (awvalid && s_q.awready) begin
      s_d.awready = 1'b0;
      s_d.widx = awaddr[19:2];
    end
    if (wvalid && s_q.wready) begin
      s_d.wready = 1'b0;
      s_d.wdata = wdata[7:0];
      s_d.wlane0 = wstrb[0];
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (!s_q.awready && !s_q.wready && !s_q.bvalid) begin
      req.wr = s_q.wlane0;
      s_d.bvalid = 1'b1;
      s_d.bresp = rsp.wr_ok ? `MCR_RESP_OKAY : `MCR_RESP_SLVERR;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
    if (arvalid && s_q.arready) begin
      req.rd = 1'b1;
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = rsp.rdata;
      s_d.rresp = rsp.rd_ok ? `MCR_RESP_OKAY : `MCR_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign arready = s_q.arready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rresp = s_q.rresp;
  assign rdata = {24'h000000, s_q.rdata};
endmodule

// *** verif/mcr_regs_asserts.sv ***
`timescale 1ns/10ps
module mcr_regs_asserts (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic [3:0] FIFO_UNDERRUN_EVENT,
  input wire logic [3:0] FIFO_OVERRUN_EVENT,
  input wire logic COHERENCE_EVENT,
  input wire logic BURST_LENGTH_SELECT,
  input wire logic [2:0] BURST_WORDS,
  input wire logic MEMCTL_FIFO_IRQ,
  input wire logic MEMCTL_MISC_IRQ,
  input wire logic IRQ
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);
  // Bus requests taken by the slave
  sequence s_rd_take;
    ARVALID && ARREADY;
  endsequence
  sequence s_wr_take;
    AWVALID && AWREADY && WVALID && WREADY && !BVALID;
  endsequence
  a_burst_words: assert property (
    BURST_WORDS == (BURST_LENGTH_SELECT ? 3'h4 : 3'h2))
    else $error("burst size mismatch");
  a_read_answer: assert property (s_rd_take |=> RVALID)
    else $error("read answer late");
  a_read_block: assert property (RVALID |-> !ARREADY)
    else $error("read accepted while busy");
  a_write_answer: assert property (s_wr_take |-> ##2 BVALID)
    else $error("write answer late");
  a_write_hold: assert property (
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write answer dropped");
  a_fifo_cause: assert property (
    $rose(MEMCTL_FIFO_IRQ) |->
    $past(|{FIFO_UNDERRUN_EVENT, FIFO_OVERRUN_EVENT}, 4))
    else $error("fifo summary without event");
  a_misc_cause: assert property (
    $rose(MEMCTL_MISC_IRQ) |-> $past(COHERENCE_EVENT, 4))
    else $error("misc summary without event");
  a_irq_quiet: assert property (
    !MEMCTL_FIFO_IRQ && !MEMCTL_MISC_IRQ |=> !IRQ)
    else $error("irq without summary");
endmodule

bind mcr_regs mcr_regs_asserts mcr_regs_asserts_inst (.*);

// *** verif/test_mcr_regs.sv ***
`timescale 1ns/10ps
`include "mcr_consts.svh"
module test_mcr_regs;
  logic MCLK = 0, SYS_RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic ARVALID = 0, RREADY = 1, COHERENCE_EVENT = 0;
  logic [19:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, RDATA;
  logic [3:0] WSTRB = 4'hf, FIFO_UNDERRUN_EVENT = 0, FIFO_OVERRUN_EVENT = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, BURST_LENGTH_SELECT;
  logic OUTPUT_CLOCK_SELECT, MEMCTL_FIFO_IRQ, MEMCTL_MISC_IRQ, IRQ;
  logic [1:0] BRESP, RRESP, INPUT_CLOCK_SELECT;
  logic [2:0] BURST_WORDS, PLL_NUMERATOR, PLL_DENOMINATOR;
  int error_cnt = 0, compares = 0;
  always #12.5 MCLK = ~MCLK;
  mcr_regs mcr_regs_inst (.*);
  // Verdict and end of run
  task automatic finish_test();
    $display("Counts: %0d errors, %0d compares", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  // Bounded wait for a handshake signal
  task automatic await(ref logic s);
    int n = 0;
    do @(posedge MCLK); while (s !== 1'b1 && ++n < 40);
    if (n >= 40) begin
      error_cnt++;
      finish_test();
    end
  endtask
  // Write; response code 3 means not judged
  task automatic wr(input logic [17:0] i, input logic [7:0] d,
                    input logic [1:0] r = `MCR_RESP_OKAY);
    logic a = 0, w = 0;
    @(posedge MCLK);
    AWADDR <= {i, 2'b00};
    WDATA <= {24'h0, d};
    AWVALID <= 1;
    WVALID <= 1;
    BREADY <= 1;
    for (int n = 0; !(a && w); n++) begin
      @(posedge MCLK);
      a = a | AWREADY;
      w = w | WREADY;
      AWVALID <= !a;
      WVALID <= !w;
      if (n > 40) begin
        error_cnt++;
        finish_test();
      end
    end
    await(BVALID);
    if (r != 2'h3) chk(BRESP, r);
    BREADY <= 0;
  endtask
  task automatic rd(input logic [17:0] i, input logic [7:0] d,
                    input logic [1:0] r = `MCR_RESP_OKAY);
    @(posedge MCLK);
    ARADDR <= {i, 2'b00};
    ARVALID <= 1;
    await(ARREADY);
    ARVALID <= 0;
    await(RVALID);
    chk(RDATA, {24'h0, d});
    chk(RRESP, r);
  endtask
  task automatic t_reset();
    chk(BURST_WORDS, 3'h2);
    rd(`MCR_IDX_BURST_CLK, 8'h00);
    rd(`MCR_IDX_PLL, 8'h00);
    rd(`MCR_IDX_FIFO_FLAGS, 8'h00);
    rd(`MCR_IDX_COH_FLAGS, 8'h00);
    $display("reset test done");
  endtask
  // Every clock code, with reserved bits written as ones
  task automatic t_clock();
    for (int k = 0; k < 4; k++) begin
      wr(`MCR_IDX_BURST_CLK, {k[1], 3'h7, k[1:0], 1'b1, k[0]});
      chk(BURST_LENGTH_SELECT, k[0]);
      chk(BURST_WORDS, k[0] ? 3'h4 : 3'h2);
      chk(INPUT_CLOCK_SELECT, k[1:0]);
      chk(OUTPUT_CLOCK_SELECT, k[1]);
      rd(`MCR_IDX_BURST_CLK, {k[1], 3'h0, k[1:0], 1'b0, k[0]});
    end
    wr(`MCR_IDX_PLL, 8'hff);
    chk({PLL_NUMERATOR, PLL_DENOMINATOR}, 6'h3f);
    rd(`MCR_IDX_PLL, 8'hee);
    wr(`MCR_IDX_PLL, 8'h46);
    chk({PLL_NUMERATOR, PLL_DENOMINATOR}, 6'h1a);
    $display("clock test done");
  endtask
  task automatic t_fifo();
    wr(`MCR_IDX_FIFO_EN, 8'h0f);
    FIFO_UNDERRUN_EVENT <= 4'ha;
    FIFO_OVERRUN_EVENT <= 4'hf;
    cyc(6);
    rd(`MCR_IDX_FIFO_FLAGS, 8'h0a);
    wr(`MCR_IDX_FIFO_EN, 8'hf0);
    cyc(6);
    rd(`MCR_IDX_FIFO_FLAGS, 8'hf0);
    wr(`MCR_IDX_FIFO_FLAGS, 8'h00, 2'h3);
    rd(`MCR_IDX_FIFO_FLAGS, 8'hf0);
    chk(MEMCTL_FIFO_IRQ, 1'b1);
    wr(`MCR_IDX_IRQ_MASK, 8'h00);
    cyc(2);
    chk(IRQ, 1'b0);
    wr(`MCR_IDX_IRQ_MASK, 8'h01);
    cyc(2);
    chk(IRQ, 1'b1);
    rd(`MCR_IDX_IRQ_STAT, 8'h01);
    rd(`MCR_IDX_IRQ_STAT, 8'h00);
    chk(IRQ, 1'b0);
    FIFO_UNDERRUN_EVENT <= 4'h0;
    FIFO_OVERRUN_EVENT <= 4'h0;
    cyc(6);
    FIFO_OVERRUN_EVENT <= 4'h1;
    cyc(6);
    chk(MEMCTL_FIFO_IRQ, 1'b1);
    wr(`MCR_IDX_IRQ_STAT, 8'h01);
    cyc(2);
    chk({MEMCTL_FIFO_IRQ, IRQ}, 2'h0);
    FIFO_OVERRUN_EVENT <= 4'h0;
    $display("fifo test done");
  endtask
  task automatic t_coh();
    COHERENCE_EVENT <= 1;
    cyc(6);
    rd(`MCR_IDX_COH_FLAGS, 8'h00);
    chk(MEMCTL_MISC_IRQ, 1'b0);
    wr(`MCR_IDX_ERR_EN, 8'hff);
    rd(`MCR_IDX_ERR_EN, 8'h80);
    rd(`MCR_IDX_COH_FLAGS, 8'h80);
    chk(MEMCTL_MISC_IRQ, 1'b1);
    wr(`MCR_IDX_IRQ_MASK, 8'h02);
    cyc(2);
    chk(IRQ, 1'b1);
    rd(`MCR_IDX_IRQ_STAT, 8'h02);
    cyc(2);
    chk({MEMCTL_MISC_IRQ, IRQ}, 2'h0);
    COHERENCE_EVENT <= 0;
    $display("coherence test done");
  endtask
  // Unmapped and reserved places
  task automatic t_bad();
    wr(18'h30b07, 8'hff, `MCR_RESP_SLVERR);
    rd(18'h30b07, 8'h00, `MCR_RESP_SLVERR);
    wr(`MCR_IDX_RSV_A, 8'hff);
    rd(`MCR_IDX_RSV_A, 8'h00);
    rd(`MCR_IDX_RSV_C, 8'h00);
    // A write without the low byte lane leaves the register alone
    WSTRB <= 4'he;
    wr(`MCR_IDX_PLL, 8'h00);
    WSTRB <= 4'hf;
    rd(`MCR_IDX_PLL, 8'h46);
    $display("reserved test done");
  endtask
  // Main sequence
  initial begin
    cyc(4);
    SYS_RST <= 0;
    t_reset();
    t_clock();
    t_fifo();
    t_coh();
    t_bad();
    finish_test();
  end
endmodule
